/* File: rtl/host_serial_port.v */
// What this block does
// - transmit, receive and two handshake lines form a plain asynchronous serial port.
// - bit rate, parity none/even/odd, stop bits and flow control are configurable.
// - after power-up, settings come from external flash, not hardwired defaults.
// - both sides flow control via request/clear-to-send; stop sending when peer not ready.
// - request-to-send is an output, low meaning received data can be accepted.
// - ring indicator signals an incoming radio call or connection request.
// - a configurable mode keeps the ring indication monitored continuously.
// - in high speed mode, data-set-ready dropping ends the connection or requests command mode.
// - host transmit feeds device receive; device transmit feeds host receive.
// - data-terminal-ready output, active low, shares general purpose line three.
// - bit rates from 1200 up to 921600 baud are selectable.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "host_serial_defines.vh"
module host_serial_port (
	input wire ref_clk,
	input wire resetn,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData_q,
	input wire serialRxd,
	output wire serialTxd,
	input wire ctsN,
	output reg rtsN_q,
	input wire dsrN,
	output reg generalLineThreeN_q,
	output reg incomingCallIndicatorN_q,
	input wire radioIncoming,
	input wire radioConnected,
	output reg dropConnection_q,
	output reg enterCommandMode_q,
	output reg cfgLoadReq_q,
	input wire cfgLoadValid,
	input wire [7:0] cfgLoadCfg,
	input wire [15:0] cfgLoadDivisor
);
	wire [31:0] divMinFull = `HSP_DIV_MIN;
	wire [31:0] divMaxFull = `HSP_DIV_MAX;
	wire [15:0] divMin = divMinFull[15:0];
	wire [15:0] divMax = divMaxFull[15:0];

	reg [7:0] cfg_q;
	reg [15:0] div_q;
	reg loaded_q;
	reg rxHold_q;
	reg [7:0] txHold_q;
	reg txPend_q;
	reg [7:0] rxData_q;
	reg rxValid_q;
	reg parErr_q;
	reg frameErr_q;
	reg overrun_q;
	reg ringPending_q;
	reg dropSeen_q;
	reg cmdSeen_q;

	// pin synchronisers: first stage read only by the second
	// reset to the idle levels so release gives no false edge
	reg rxdMeta_q;
	reg rxdSync_q;
	reg ctsMeta_q;
	reg ctsSync_q;
	reg dsrMeta_q;
	reg dsrSync_q;
	reg dsrPrev_q;

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rxdMeta_q <= 1'b1;
			rxdSync_q <= 1'b1;
			ctsMeta_q <= 1'b1;
			ctsSync_q <= 1'b1;
			dsrMeta_q <= 1'b1;
			dsrSync_q <= 1'b1;
			dsrPrev_q <= 1'b1;
		end else begin
			rxdMeta_q <= serialRxd;
			rxdSync_q <= rxdMeta_q;
			ctsMeta_q <= ctsN;
			ctsSync_q <= ctsMeta_q;
			dsrMeta_q <= dsrN;
			dsrSync_q <= dsrMeta_q;
			dsrPrev_q <= dsrSync_q;
		end
	end

	// an out of range divisor snaps to the nearest legal bit rate
	function [15:0] clampDiv;
		input [15:0] d;
		input [15:0] lo;
		input [15:0] hi;
		begin
			if (d < lo)
				clampDiv = lo;
			else if (d > hi)
				clampDiv = hi;
			else
				clampDiv = d;
		end
	endfunction

	wire parityEn = cfg_q[`HSP_CFG_PAR_EN];
	wire parityOdd = cfg_q[`HSP_CFG_PAR_ODD];
	wire twoStop = cfg_q[`HSP_CFG_TWO_STOP];
	wire flowEn = cfg_q[`HSP_CFG_FLOW_EN];
	wire ringMon = cfg_q[`HSP_CFG_RING_MON];
	wire highSpeed = cfg_q[`HSP_CFG_HIGH_SPEED];
	wire dsrToCmd = cfg_q[`HSP_CFG_DSR_CMD];

	wire txBusy;
	// a frame already on the wire finishes even if the peer pauses
	wire ctsPermit = !flowEn || !ctsSync_q;
	wire txStart = loaded_q && txPend_q && !txBusy && ctsPermit;

	serial_tx txUnit (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.divisor(div_q),
		.parityEn(parityEn),
		.parityOdd(parityOdd),
		.twoStop(twoStop),
		.start(txStart),
		.data(txHold_q),
		.txd_q(serialTxd),
		.busy(txBusy)
	);

	wire [7:0] rxByte;
	wire rxDone;
	wire rxParErr;
	wire rxFrameErr;

	// receive waits for the flash image so the bit rate is known
	serial_rx rxUnit (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.enable(loaded_q),
		.divisor(div_q),
		.parityEn(parityEn),
		.parityOdd(parityOdd),
		.rxd(rxdSync_q),
		.data_q(rxByte),
		.done_q(rxDone),
		.parityErr_q(rxParErr),
		.frameErr_q(rxFrameErr)
	);

	// before the flash image lands only control writes act
	wire wrCfg = regWr && loaded_q && (regAddr == `HSP_ADDR_CFG);
	wire wrDiv = regWr && loaded_q && (regAddr == `HSP_ADDR_DIV);
	wire wrTx = regWr && loaded_q && (regAddr == `HSP_ADDR_TXDATA);
	wire wrCtrl = regWr && (regAddr == `HSP_ADDR_CTRL);
	wire rdRx = regRd && (regAddr == `HSP_ADDR_RXDATA);
	wire clrErr = wrCtrl && regWrData[`HSP_CTRL_CLR_ERR];
	wire clrRing = wrCtrl && regWrData[`HSP_CTRL_CLR_RING];
	wire clrDsr = wrCtrl && regWrData[`HSP_CTRL_CLR_DSR];

	// host releasing its terminal-ready while the link runs fast
	wire dsrDrop = loaded_q && highSpeed && !dsrPrev_q && dsrSync_q;

	// configuration: flash image first, software may retune afterwards
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= `HSP_CFG_RESET;
			div_q <= `HSP_DIV_RESET;
			loaded_q <= 1'b0;
			cfgLoadReq_q <= 1'b1;
			rxHold_q <= 1'b0;
		end else begin
			if (cfgLoadReq_q && cfgLoadValid) begin
				cfg_q <= cfgLoadCfg;
				div_q <= clampDiv(cfgLoadDivisor, divMin, divMax);
				loaded_q <= 1'b1;
				cfgLoadReq_q <= 1'b0;
			end
			// a software cfg or divisor write in the load cycle is ignored, loaded_q is still low
			if (wrCfg)
				cfg_q <= regWrData[7:0];
			if (wrDiv)
				div_q <= clampDiv(regWrData[15:0], divMin, divMax);
			if (wrCtrl)
				rxHold_q <= regWrData[`HSP_CTRL_RX_HOLD];
		end
	end

	// transmit holding byte; a write while one waits is dropped
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			txHold_q <= 8'h00;
			txPend_q <= 1'b0;
		end else if (txStart) begin
			txPend_q <= 1'b0;
		end else if (wrTx && !txPend_q) begin
			txHold_q <= regWrData[7:0];
			txPend_q <= 1'b1;
		end
	end

	// receive holding byte and sticky error flags, set wins over clear
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rxData_q <= 8'h00;
			rxValid_q <= 1'b0;
			parErr_q <= 1'b0;
			frameErr_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (rxDone && (!rxValid_q || rdRx)) begin
				rxData_q <= rxByte;
				rxValid_q <= 1'b1;
			end else if (rdRx) begin
				rxValid_q <= 1'b0;
			end
			if (rxDone && rxParErr)
				parErr_q <= 1'b1;
			else if (clrErr)
				parErr_q <= 1'b0;
			if (rxDone && rxFrameErr)
				frameErr_q <= 1'b1;
			else if (clrErr)
				frameErr_q <= 1'b0;
			// a byte arriving while one waits unread is lost, the old one kept
			if (rxDone && rxValid_q && !rdRx)
				overrun_q <= 1'b1;
			else if (clrErr)
				overrun_q <= 1'b0;
		end
	end

	// handshake, ring and connection lines
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rtsN_q <= 1'b1;
			generalLineThreeN_q <= 1'b1;
			incomingCallIndicatorN_q <= 1'b1;
			ringPending_q <= 1'b0;
			dropSeen_q <= 1'b0;
			cmdSeen_q <= 1'b0;
			dropConnection_q <= 1'b0;
			enterCommandMode_q <= 1'b0;
		end else begin
			// ready only with the holding byte free; without flow control stay asserted
			rtsN_q <= !(loaded_q && (!flowEn || (!rxValid_q && !rxHold_q)));
			generalLineThreeN_q <= !(loaded_q && radioConnected);
			if (ringMon && radioIncoming)
				ringPending_q <= 1'b1;
			else if (clrRing || !ringMon)
				ringPending_q <= 1'b0;
			incomingCallIndicatorN_q <= !(loaded_q && (radioIncoming || ringPending_q));
			// one cycle pulses; sticky copies let software see them later
			dropConnection_q <= dsrDrop && !dsrToCmd;
			enterCommandMode_q <= dsrDrop && dsrToCmd;
			if (dsrDrop && !dsrToCmd)
				dropSeen_q <= 1'b1;
			else if (clrDsr)
				dropSeen_q <= 1'b0;
			if (dsrDrop && dsrToCmd)
				cmdSeen_q <= 1'b1;
			else if (clrDsr)
				cmdSeen_q <= 1'b0;
		end
	end

	// sticky bits clear through the control register; the ring bit also clears when ring monitoring is off
	reg [31:0] statusWord;
	always @* begin
		statusWord = 32'h00000000;
		statusWord[`HSP_ST_TX_BUSY] = txPend_q || txBusy;
		statusWord[`HSP_ST_RX_VALID] = rxValid_q;
		statusWord[`HSP_ST_PAR_ERR] = parErr_q;
		statusWord[`HSP_ST_FRAME_ERR] = frameErr_q;
		statusWord[`HSP_ST_OVERRUN] = overrun_q;
		statusWord[`HSP_ST_CTS] = !ctsSync_q;
		statusWord[`HSP_ST_DSR] = !dsrSync_q;
		statusWord[`HSP_ST_RING] = ringPending_q;
		statusWord[`HSP_ST_DROP] = dropSeen_q;
		statusWord[`HSP_ST_CMD] = cmdSeen_q;
		statusWord[`HSP_ST_LOADED] = loaded_q;
	end

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData_q <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				`HSP_ADDR_CFG: regRdData_q <= {24'h000000, cfg_q};
				`HSP_ADDR_DIV: regRdData_q <= {16'h0000, div_q};
				`HSP_ADDR_RXDATA: regRdData_q <= {24'h000000, rxData_q};
				`HSP_ADDR_STATUS: regRdData_q <= statusWord;
				`HSP_ADDR_CTRL: regRdData_q <= {28'h0000000, rxHold_q, 3'h0};
				default: regRdData_q <= 32'h00000000;
			endcase
		end else begin
			regRdData_q <= 32'h00000000;
		end
	end
endmodule

/* File: rtl/host_serial_defines.vh */
`ifndef HOST_SERIAL_DEFINES_VH
`define HOST_SERIAL_DEFINES_VH

// clock and bit rate limits
`define HSP_CLK_HZ 32'h01312d00
`define HSP_BAUD_MAX 32'h000e1000
`define HSP_BAUD_MIN 32'h000004b0
`define HSP_DIV_MIN ((`HSP_CLK_HZ) / (`HSP_BAUD_MAX))
`define HSP_DIV_MAX ((`HSP_CLK_HZ) / (`HSP_BAUD_MIN))
`define HSP_DIV_RESET 16'h0000

// register byte addresses
`define HSP_ADDR_CFG 8'h00
`define HSP_ADDR_DIV 8'h04
`define HSP_ADDR_TXDATA 8'h08
`define HSP_ADDR_RXDATA 8'h0c
`define HSP_ADDR_STATUS 8'h10
`define HSP_ADDR_CTRL 8'h14

// configuration fields
`define HSP_CFG_PAR_EN 0
`define HSP_CFG_PAR_ODD 1
`define HSP_CFG_TWO_STOP 2
`define HSP_CFG_FLOW_EN 3
`define HSP_CFG_RING_MON 4
`define HSP_CFG_HIGH_SPEED 5
`define HSP_CFG_DSR_CMD 6
`define HSP_CFG_RESET 8'h00

// status fields
`define HSP_ST_TX_BUSY 0
`define HSP_ST_RX_VALID 1
`define HSP_ST_PAR_ERR 2
`define HSP_ST_FRAME_ERR 3
`define HSP_ST_OVERRUN 4
`define HSP_ST_CTS 5
`define HSP_ST_DSR 6
`define HSP_ST_RING 7
`define HSP_ST_DROP 8
`define HSP_ST_CMD 9
`define HSP_ST_LOADED 10

// control write fields
`define HSP_CTRL_CLR_ERR 0
`define HSP_CTRL_CLR_RING 1
`define HSP_CTRL_CLR_DSR 2
`define HSP_CTRL_RX_HOLD 3

// frame state codes and the last data bit index
`define HSP_S_IDLE 3'h0
`define HSP_S_START 3'h1
`define HSP_S_DATA 3'h2
`define HSP_S_PARITY 3'h3
`define HSP_S_STOP 3'h4
`define HSP_LAST_BIT 3'h7

`endif

/* File: rtl/serial_tx.v */
`timescale 1ns/1ps
`include "host_serial_defines.vh"
module serial_tx (
	input wire ref_clk,
	input wire resetn,
	input wire [15:0] divisor,
	input wire parityEn,
	input wire parityOdd,
	input wire twoStop,
	input wire start,
	input wire [7:0] data,
	output reg txd_q,
	output wire busy
);
	localparam IDLE = `HSP_S_IDLE;
	localparam START = `HSP_S_START;
	localparam DATA = `HSP_S_DATA;
	localparam PARITY = `HSP_S_PARITY;
	localparam STOP = `HSP_S_STOP;
	reg [2:0] state_q;
	reg [15:0] cnt_q;
	reg [2:0] bitIdx_q;
	reg [7:0] shift_q;
	reg par_q;
	reg stopLeft_q;
	wire tick = (cnt_q == 16'h0000);
	assign busy = (state_q != IDLE);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= IDLE;
			cnt_q <= 16'h0000;
			bitIdx_q <= 3'h0;
			shift_q <= 8'h00;
			par_q <= 1'b0;
			stopLeft_q <= 1'b0;
			txd_q <= 1'b1;
		end else if (state_q == IDLE) begin
			txd_q <= 1'b1;
			if (start) begin
				shift_q <= data;
				par_q <= parityOdd;
				cnt_q <= divisor - 16'h0001;
				txd_q <= 1'b0;
				state_q <= START;
			end
		end else if (!tick) begin
			cnt_q <= cnt_q - 16'h0001;
		end else begin
			cnt_q <= divisor - 16'h0001;
			case (state_q)
				START: begin
					txd_q <= shift_q[0];
					par_q <= par_q ^ shift_q[0];
					shift_q <= {1'b0, shift_q[7:1]};
					bitIdx_q <= 3'h0;
					state_q <= DATA;
				end
				DATA: begin
					if (bitIdx_q == `HSP_LAST_BIT) begin
						stopLeft_q <= twoStop;
						if (parityEn) begin
							txd_q <= par_q;
							state_q <= PARITY;
						end else begin
							txd_q <= 1'b1;
							state_q <= STOP;
						end
					end else begin
						bitIdx_q <= bitIdx_q + 3'h1;
						txd_q <= shift_q[0];
						par_q <= par_q ^ shift_q[0];
						shift_q <= {1'b0, shift_q[7:1]};
					end
				end
				PARITY: begin
					txd_q <= 1'b1;
					state_q <= STOP;
				end
				STOP: begin
					if (stopLeft_q)
						stopLeft_q <= 1'b0;
					else
						state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end
endmodule

/* File: rtl/serial_rx.v */
`timescale 1ns/1ps
`include "host_serial_defines.vh"
module serial_rx (
	input wire ref_clk,
	input wire resetn,
	input wire enable,
	input wire [15:0] divisor,
	input wire parityEn,
	input wire parityOdd,
	input wire rxd,
	output reg [7:0] data_q,
	output reg done_q,
	output reg parityErr_q,
	output reg frameErr_q
);
	localparam IDLE = `HSP_S_IDLE;
	localparam START = `HSP_S_START;
	localparam DATA = `HSP_S_DATA;
	localparam PARITY = `HSP_S_PARITY;
	localparam STOP = `HSP_S_STOP;
	reg [2:0] state_q;
	reg [15:0] cnt_q;
	reg [2:0] bitIdx_q;
	reg [7:0] shift_q;
	reg par_q;
	reg parBad_q;
	wire tick = (cnt_q == 16'h0000);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= IDLE;
			cnt_q <= 16'h0000;
			bitIdx_q <= 3'h0;
			shift_q <= 8'h00;
			par_q <= 1'b0;
			parBad_q <= 1'b0;
			data_q <= 8'h00;
			done_q <= 1'b0;
			parityErr_q <= 1'b0;
			frameErr_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (state_q == IDLE) begin
				// half a bit to land mid start bit
				if (enable && !rxd) begin
					cnt_q <= {1'b0, divisor[15:1]};
					state_q <= START;
				end
			end else if (!tick) begin
				cnt_q <= cnt_q - 16'h0001;
			end else begin
				cnt_q <= divisor - 16'h0001;
				case (state_q)
					START: begin
						// a short low glitch is not a frame
						if (rxd)
							state_q <= IDLE;
						else begin
							bitIdx_q <= 3'h0;
							par_q <= parityOdd;
							parBad_q <= 1'b0;
							state_q <= DATA;
						end
					end
					DATA: begin
						shift_q <= {rxd, shift_q[7:1]};
						par_q <= par_q ^ rxd;
						bitIdx_q <= bitIdx_q + 3'h1;
						if (bitIdx_q == `HSP_LAST_BIT)
							state_q <= parityEn ? PARITY : STOP;
					end
					PARITY: begin
						parBad_q <= (rxd != par_q);
						state_q <= STOP;
					end
					STOP: begin
						// only the first stop bit is checked so back-to-back frames resync
						data_q <= shift_q;
						done_q <= 1'b1;
						parityErr_q <= parBad_q;
						frameErr_q <= !rxd;
						state_q <= IDLE;
					end
					default: state_q <= IDLE;
				endcase
			end
		end
	end
endmodule

/* File: tb/host_serial_port_sva.sv */
`timescale 1ns/1ps
module host_serial_port_sva (
	input wire ref_clk,
	input wire resetn,
	input wire regRd,
	input wire [31:0] regRdData_q,
	input wire serialTxd,
	input wire rtsN_q,
	input wire dsrN,
	input wire generalLineThreeN_q,
	input wire incomingCallIndicatorN_q,
	input wire radioConnected,
	input wire dropConnection_q,
	input wire enterCommandMode_q,
	input wire cfgLoadReq_q,
	input wire cfgLoadValid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_loadTaken;
		cfgLoadReq_q && cfgLoadValid;
	endsequence
	sequence s_dsrReleased;
		$past(dsrN, 3) && !$past(dsrN, 4);
	endsequence
	sequence s_pulseGone;
		!dropConnection_q && !enterCommandMode_q;
	endsequence
	a_rd_idle_zero: assert property (!regRd |=> regRdData_q == 32'h0) else $error("read data not zero");
	a_load_once: assert property (s_loadTaken |=> !cfgLoadReq_q [*8]) else $error("load request back");
	a_rts_unloaded: assert property (cfgLoadReq_q |-> rtsN_q) else $error("rts low before load");
	a_txd_unloaded: assert property (cfgLoadReq_q |-> serialTxd) else $error("txd not idle high");
	a_ring_loaded: assert property (!incomingCallIndicatorN_q |-> !cfgLoadReq_q) else $error("ring early");
	a_dtr_up: assert property (!cfgLoadReq_q && radioConnected |=> !generalLineThreeN_q) else $error("dtr high");
	a_dtr_down: assert property (!radioConnected |=> generalLineThreeN_q) else $error("dtr low");
	a_drop_cause: assert property (dropConnection_q |-> s_dsrReleased ##0 !enterCommandMode_q ##1 s_pulseGone)
		else $error("drop pulse bad");
	a_cmd_cause: assert property (enterCommandMode_q |-> s_dsrReleased ##0 !dropConnection_q ##1 s_pulseGone)
		else $error("cmd pulse bad");
endmodule
bind host_serial_port host_serial_port_sva u_sva (.ref_clk, .resetn, .regRd, .regRdData_q, .serialTxd, .rtsN_q,
	.dsrN, .generalLineThreeN_q, .incomingCallIndicatorN_q, .radioConnected, .dropConnection_q,
	.enterCommandMode_q, .cfgLoadReq_q, .cfgLoadValid);

/* File: tb/host_uart_model.sv */
`timescale 1ns/1ps
module host_uart_model #(parameter int DIV = 21) (
	input wire logic ref_clk,
	input wire logic txdIn,
	input wire logic rtsIn,
	output logic rxdOut
);
	logic parOn = 1'b0;
	logic [7:0] gotByte;
	logic gotPar;
	logic gotStop;
	int gotCount = 0;
	initial rxdOut = 1'b1;
	task automatic send_byte(input logic [7:0] b, input logic badPar);
		@(posedge ref_clk);
		while (rtsIn)
			@(posedge ref_clk);
		rxdOut <= 1'b0;
		repeat (DIV) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			rxdOut <= b[i];
			repeat (DIV) @(posedge ref_clk);
		end
		if (parOn) begin
			rxdOut <= ^b ^ badPar;
			repeat (DIV) @(posedge ref_clk);
		end
		rxdOut <= 1'b1;
		repeat (DIV) @(posedge ref_clk);
	endtask
	// sample on the falling clock edge, away from the device's launch edge
	always begin
		@(negedge txdIn);
		repeat (DIV / 2) @(negedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(negedge ref_clk);
			gotByte[i] = txdIn;
		end
		if (parOn) begin
			repeat (DIV) @(negedge ref_clk);
			gotPar = txdIn;
		end
		repeat (DIV) @(negedge ref_clk);
		gotStop = txdIn;
		gotCount++;
	end
endmodule

/* File: tb/host_serial_port_tb_top.sv */
`timescale 1ns/1ps
module host_serial_port_tb_top;
	logic ref_clk, resetn, regWr, regRd, ctsN, dsrN, radioIncoming, radioConnected, cfgLoadValid;
	logic serialRxd, serialTxd, rtsN_q, generalLineThreeN_q, incomingCallIndicatorN_q;
	logic dropConnection_q, enterCommandMode_q, cfgLoadReq_q;
	logic [7:0] regAddr, cfgLoadCfg;
	logic [15:0] cfgLoadDivisor;
	logic [31:0] regWrData, regRdData_q, rdv;
	int n_errors = 0;
	int checks = 0;
	host_serial_port u_host_serial_port (.ref_clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
		.serialRxd, .serialTxd, .ctsN, .rtsN_q, .dsrN, .generalLineThreeN_q, .incomingCallIndicatorN_q,
		.radioIncoming, .radioConnected, .dropConnection_q, .enterCommandMode_q, .cfgLoadReq_q, .cfgLoadValid,
		.cfgLoadCfg, .cfgLoadDivisor);
	host_uart_model #(.DIV(21)) u_host_uart_model (.ref_clk, .txdIn(serialTxd), .rtsIn(rtsN_q), .rxdOut(serialRxd));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task cycles(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 rdv = regRdData_q;
	endtask
	task do_reset;
		@(posedge ref_clk);
		resetn <= 1'b0;
		cycles(5);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
	endtask
	task t_load;
		chk("cfgLoadReq", 1, cfgLoadReq_q);
		chk("rtsN unloaded", 1, rtsN_q);
		wr(8'h04, 32'h15);
		rd(8'h04);
		chk("div before load", 0, rdv);
		@(posedge ref_clk);
		cfgLoadValid <= 1'b1;
		cfgLoadCfg <= 8'h09;
		cfgLoadDivisor <= 16'd21;
		@(posedge ref_clk);
		cfgLoadValid <= 1'b0;
		rd(8'h10);
		chk("loaded", 1, rdv[10]);
		rd(8'h00);
		chk("cfg", 32'h09, rdv);
		cycles(3);
		chk("rtsN ready", 0, rtsN_q);
		rd(8'h20);
		chk("unmapped", 0, rdv);
		$display("load test done");
	endtask
	task t_div;
		wr(8'h04, 32'h5);
		rd(8'h04);
		chk("div low clamp", 32'h15, rdv);
		wr(8'h04, 32'hffff);
		rd(8'h04);
		chk("div high clamp", 32'h411a, rdv);
		wr(8'h04, 32'h15);
		$display("divisor test done");
	endtask
	task t_tx;
		logic [7:0] cfgs [3];
		logic [7:0] b;
		int n0;
		cfgs = '{8'h09, 8'h0b, 8'h08};
		@(posedge ref_clk);
		ctsN <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			b = 8'ha5 ^ 8'(m * 8'h33);
			wr(8'h00, {24'h0, cfgs[m]});
			u_host_uart_model.parOn = cfgs[m][0];
			n0 = u_host_uart_model.gotCount;
			wr(8'h08, {24'h0, b});
			if (m == 0) begin
				cycles(60);
				chk("txd held", 1, serialTxd);
				@(posedge ref_clk);
				ctsN <= 1'b0;
			end
			for (int k = 0; k < 400 && u_host_uart_model.gotCount == n0; k++) @(posedge ref_clk);
			chk("tx frame seen", 1, u_host_uart_model.gotCount != n0);
			chk("tx byte", b, u_host_uart_model.gotByte);
			chk("tx stop", 1, u_host_uart_model.gotStop);
			if (cfgs[m][0])
				chk("tx parity", cfgs[m][1] ? ~^b : ^b, u_host_uart_model.gotPar);
		end
		$display("transmit test done");
	endtask
	task t_rx;
		wr(8'h00, 32'h09);
		u_host_uart_model.parOn = 1'b1;
		u_host_uart_model.send_byte(8'h3c, 1'b0);
		cycles(4);
		chk("rtsN full", 1, rtsN_q);
		rd(8'h0c);
		chk("rx byte", 32'h3c, rdv);
		cycles(3);
		chk("rtsN free", 0, rtsN_q);
		u_host_uart_model.send_byte(8'h5a, 1'b1);
		cycles(4);
		rd(8'h10);
		chk("parity err", 1, rdv[2]);
		rd(8'h0c);
		chk("rx byte bad", 32'h5a, rdv);
		wr(8'h14, 32'h1);
		rd(8'h10);
		chk("parity clear", 0, rdv[2]);
		$display("receive test done");
	endtask
	task t_modes;
		int n0;
		wr(8'h00, 32'h04);
		u_host_uart_model.parOn = 1'b0;
		n0 = u_host_uart_model.gotCount;
		@(posedge ref_clk);
		ctsN <= 1'b1;
		wr(8'h08, 32'h81);
		for (int k = 0; k < 400 && u_host_uart_model.gotCount == n0; k++) @(posedge ref_clk);
		chk("flow off frame", 1, u_host_uart_model.gotCount != n0);
		chk("flow off byte", 32'h81, u_host_uart_model.gotByte);
		cycles(21);
		rd(8'h10);
		chk("second stop busy", 1, rdv[0]);
		cycles(21);
		rd(8'h10);
		chk("stops done", 0, rdv[0]);
		u_host_uart_model.send_byte(8'h11, 1'b0);
		u_host_uart_model.send_byte(8'h22, 1'b0);
		cycles(4);
		chk("rtsN flow off", 0, rtsN_q);
		rd(8'h10);
		chk("overrun", 1, rdv[4]);
		rd(8'h0c);
		chk("rx first kept", 32'h11, rdv);
		wr(8'h00, 32'h08);
		wr(8'h14, 32'h8);
		cycles(3);
		chk("rtsN hold", 1, rtsN_q);
		rd(8'h14);
		chk("hold readback", 32'h8, rdv);
		wr(8'h14, 32'h1);
		cycles(3);
		chk("rtsN released", 0, rtsN_q);
		@(posedge ref_clk);
		ctsN <= 1'b0;
		$display("mode test done");
	endtask
	task t_ring;
		wr(8'h00, 32'h19);
		@(posedge ref_clk);
		radioIncoming <= 1'b1;
		@(posedge ref_clk);
		radioIncoming <= 1'b0;
		cycles(5);
		chk("ring held", 0, incomingCallIndicatorN_q);
		wr(8'h14, 32'h2);
		cycles(3);
		chk("ring cleared", 1, incomingCallIndicatorN_q);
		wr(8'h00, 32'h09);
		@(posedge ref_clk);
		radioIncoming <= 1'b1;
		@(posedge ref_clk);
		radioIncoming <= 1'b0;
		cycles(5);
		chk("ring unmonitored", 1, incomingCallIndicatorN_q);
		$display("ring test done");
	endtask
	task t_dsr;
		logic sawDrop, sawCmd;
		for (int m = 0; m < 2; m++) begin
			sawDrop = 1'b0;
			sawCmd = 1'b0;
			wr(8'h00, m ? 32'h69 : 32'h29);
			cycles(4);
			dsrN <= 1'b1;
			for (int k = 0; k < 12; k++) begin
				@(posedge ref_clk);
				#1;
				sawDrop |= dropConnection_q;
				sawCmd |= enterCommandMode_q;
			end
			chk("drop", m == 0, sawDrop);
			chk("command", m == 1, sawCmd);
			rd(8'h10);
			chk("dsr status", 0, rdv[6]);
			chk("dsr seen", 1, rdv[8 + m]);
			@(posedge ref_clk);
			dsrN <= 1'b0;
		end
		wr(8'h14, 32'h4);
		rd(8'h10);
		chk("dsr seen clear", 0, rdv[9:8]);
		chk("dsr asserted", 1, rdv[6]);
		$display("dsr test done");
	endtask
	task t_dtr;
		@(posedge ref_clk);
		radioConnected <= 1'b1;
		cycles(3);
		chk("dtr on", 0, generalLineThreeN_q);
		radioConnected <= 1'b0;
		cycles(3);
		chk("dtr off", 1, generalLineThreeN_q);
		$display("dtr test done");
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("Error watchdog expired");
		stop_test;
	end
	initial begin
		{resetn, regWr, regRd, radioIncoming, radioConnected, cfgLoadValid, ctsN, dsrN} = 8'h00;
		regAddr = 8'h00;
		regWrData = 32'h0;
		cfgLoadCfg = 8'h00;
		cfgLoadDivisor = 16'h0000;
		cycles(5);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_load();
		t_div();
		t_tx();
		t_rx();
		t_modes();
		t_ring();
		t_dsr();
		t_dtr();
		do_reset();
		t_load();
		stop_test;
	end
endmodule
